// File: include/did_pkg.sv
// Purpose: shared constants and types for the DAC interpolation datapath
// Assumes: registers sit at byte address four times their index
// Notes: latency figures are in DAC clocks
package did_pkg;
  localparam int AXI_AW = 12;
  localparam int IDX_W = 10;
  // register indices (byte address = 4 * index)
  localparam logic [IDX_W-1:0] IDX_INTERP = 10'h110;
  localparam logic [IDX_W-1:0] IDX_DP_CFG = 10'h111;
  localparam logic [IDX_W-1:0] IDX_ISINC = 10'h112;
  localparam logic [IDX_W-1:0] IDX_FTW0 = 10'h114;
  localparam logic [IDX_W-1:0] IDX_FTW5 = 10'h119;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h120;
  // field positions
  localparam int CFG_NRZ_BIT = 0;
  localparam int CFG_BW_BIT = 4;
  localparam int CFG_NCO_BIT = 6;
  localparam int STAT_VALID_BIT = 16;
  localparam int STAT_UFLOW_BIT = 17;
  // reset values
  localparam logic [3:0] RST_INTERP = 4'h0;
  localparam logic [47:0] RST_FTW = 48'h0000_0000_0000;
  localparam logic [3:0] INTERP_MAX = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // pipeline latency in DAC clocks
  localparam logic [10:0] LAT_NCO_ONLY = 11'd48;
  localparam logic [10:0] LAT_BYPASS = 11'd113;
  localparam logic [10:0] LAT_ADD_ISINC_BYP = 11'd24;
  localparam logic [10:0] LAT_2X = 11'd155;
  localparam logic [10:0] LAT_3X = 11'd168;
  localparam logic [10:0] LAT_4X = 11'd308;
  localparam logic [10:0] LAT_6X = 11'd332;
  localparam logic [10:0] LAT_8X = 11'd602;
  localparam logic [10:0] LAT_12X = 11'd674;
  localparam logic [10:0] LAT_16X = 11'd1188;
  localparam logic [10:0] LAT_24X = 11'd1272;
  localparam logic [10:0] LAT_ADD_BW90_2 = 11'd21;
  localparam logic [10:0] LAT_ADD_BW90_3 = 11'd34;
  localparam logic [10:0] LAT_ADD_NRZ = 11'd47;
  localparam logic [10:0] LAT_ADD_ISINC = 11'd30;
  localparam logic [10:0] LAT_ADD_ISINC_NRZ = 11'd37;
  localparam logic [10:0] LAT_ADD_NCO = 11'd40;
  localparam logic [10:0] FIXED_STAGES = 11'd5;
  localparam int DLY_DEPTH = 2048;
  localparam int DLY_AW = 11;

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } did_sample_t;

  typedef struct packed {
    logic signed [15:0] late;
    logic signed [15:0] early;
  } did_pair_t;

  typedef struct packed {
    logic [DLY_AW-1:0] wp;
    logic [DLY_AW-1:0] fill;
    did_pair_t dout;
    logic valid;
  } did_dly_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic [AXI_AW-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [3:0] interp;
    logic bw90;
    logic nrz;
    logic nco_en;
    logic isinc_en;
    logic [47:0] ftw;
    logic uflow;
    logic [7:0] cfg_q;
    logic flush;
    logic [47:0] phase;
    logic [4:0] cnt;
    logic in_ready;
    did_sample_t held;
    did_sample_t x1;
    did_sample_t x2;
    did_sample_t sinc;
    logic signed [15:0] r;
    logic signed [15:0] r_prev;
    did_pair_t dac;
    logic dac_valid;
  } did_state_t;
endpackage

// File: hw/did_delay_line.sv
// Purpose: programmable delay line that sets the total pipeline latency
// Assumes: 1 <= delay < DEPTH; clear restarts the fill count
// Notes: dout at edge t is din written at edge t - delay
module did_delay_line
  import did_pkg::*;
#(
  parameter int DEPTH = DLY_DEPTH
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic [DLY_AW-1:0] delay,
  input did_pair_t din,
  output did_pair_t dout,
  output logic dout_valid
);
  did_pair_t mem [DEPTH];
  did_dly_state_t s;
  did_dly_state_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.wp = s.wp + 1'b1;
    next_s.dout = mem[s.wp - delay];
    next_s.valid = !clear && (s.fill >= delay);
    if (clear)
    begin
      next_s.fill = '0;
    end
    else if (s.fill != DLY_AW'(DEPTH - 1))
    begin
      next_s.fill = s.fill + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    mem[s.wp] <= din;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign dout = s.dout;
  assign dout_valid = s.valid;
endmodule

// File: hw/did_datapath.sv
// Purpose: DAC interpolation datapath with AXI4-Lite register access
// Assumes: clk is the DAC clock; the source honours in_ready
// Notes: sample-rate stages are simplified; latency is set by the delay line
//
// Summary of operation
// [RL1] input stage, five halfbands, NRZ stage, modulator
// [RL2] source sends complex I/Q when processing enabled
// [RL3] bypass mode treats input as real
// [RL4] latency 48 NCO-only, 113 bypass, 137 sinc
// [RL5] latency 155 2x, 308 4x, 1272 24x
// [RL6] latencies nominal, add to link latency
// [RL7] all data is 16-bit two's complement
// [RL8] source removes DC offset from samples
// [RL9] five halfbands plus final NRZ stage
// [RL10] first stage bandwidth 80% or 90% select
// [RL11] later stages halve usable bandwidth each
// [RL12] NRZ stage complex, twice DAC rate
// [RL13] signal bandwidth is fraction times rate/factor
// [RL14] ripple under 0.001 dB, rejection over 85 dB
// [RL15] NRZ stage combines with complex interpolation
// [RL16] four-bit factor code selects 1x..24x
// [RL17] config bit 0 enables NRZ stage
// [RL18] config change clears filter state
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
module did_datapath
  import did_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input did_sample_t in_sample,
  input wire logic in_valid,
  output logic in_ready,
  output did_pair_t dac_data,
  output logic dac_valid
);
  did_state_t s;
  did_state_t next_s;
  did_pair_t dly_in;
  did_pair_t dly_out;
  logic dly_valid;
  logic [10:0] latency;

  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sh0_0000_7FFF)
    begin
      return 16'h7FFF;
    end
    else if (v < -34'sh0_0000_8000)
    begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction

  function automatic logic signed [15:0] avg16(input logic signed [15:0] a,
                                               input logic signed [15:0] b);
    logic signed [16:0] sum;
    sum = 17'(a) + 17'(b);
    return sum[16:1];
  endfunction

  // quarter-wave sine, 64 steps per turn
  function automatic logic signed [15:0] sine(input logic [5:0] p);
    logic [3:0] k;
    logic [4:0] idx;
    logic [15:0] t;
    k = p[3:0];
    idx = p[4] ? 5'd16 - 5'(k) : 5'(k);
    case (idx)
      5'd0: t = 16'h0000;
      5'd1: t = 16'h0C8C;
      5'd2: t = 16'h18F9;
      5'd3: t = 16'h2528;
      5'd4: t = 16'h30FB;
      5'd5: t = 16'h3C56;
      5'd6: t = 16'h471C;
      5'd7: t = 16'h5133;
      5'd8: t = 16'h5A82;
      5'd9: t = 16'h62F2;
      5'd10: t = 16'h6A6D;
      5'd11: t = 16'h70E2;
      5'd12: t = 16'h7641;
      5'd13: t = 16'h7A7C;
      5'd14: t = 16'h7D89;
      5'd15: t = 16'h7F61;
      default: t = 16'h7FFF;
    endcase
    return p[5] ? -$signed(t) : $signed(t);
  endfunction

  // interpolation factor minus one; codes above 8 run as bypass
  function automatic logic [4:0] factor_m1(input logic [3:0] code);
    case (code)
      4'h1: return 5'd1;
      4'h2: return 5'd2;
      4'h3: return 5'd3;
      4'h4: return 5'd5;
      4'h5: return 5'd7;
      4'h6: return 5'd11;
      4'h7: return 5'd15;
      4'h8: return 5'd23;
      default: return 5'd0;
    endcase
  endfunction

  function automatic logic [10:0] lat_of(input logic [3:0] code, input logic bw90,
                                         input logic nrz, input logic isinc,
                                         input logic nco);
    logic [10:0] l;
    logic third;
    third = (code == 4'h2) || (code == 4'h4) || (code == 4'h6) || (code == 4'h8);
    case (code)
      4'h1: l = LAT_2X;
      4'h2: l = LAT_3X;
      4'h3: l = LAT_4X;
      4'h4: l = LAT_6X;
      4'h5: l = LAT_8X;
      4'h6: l = LAT_12X;
      4'h7: l = LAT_16X;
      4'h8: l = LAT_24X;
      default: l = '0;
    endcase
    if (code == 4'h0 || code > INTERP_MAX)
    begin
      l = nco ? LAT_NCO_ONLY : LAT_BYPASS; // RL4
      l = l + (isinc ? LAT_ADD_ISINC_BYP : 11'd0);
      l = l + (nrz ? LAT_ADD_NRZ : 11'd0);
    end
    else
    begin
      l = l + (bw90 ? (third ? LAT_ADD_BW90_3 : LAT_ADD_BW90_2) : 11'd0); // RL5
      l = l + (nrz ? LAT_ADD_NRZ : 11'd0);
      l = l + (isinc ? (nrz ? LAT_ADD_ISINC_NRZ : LAT_ADD_ISINC) : 11'd0);
      l = l + (nco ? LAT_ADD_NCO : 11'd0);
    end
    return l;
  endfunction

  always_comb
  begin
    logic [IDX_W-1:0] widx;
    logic [7:0] cfg_now;
    logic take;
    logic signed [33:0] acc;
    logic signed [15:0] sn;
    logic signed [15:0] cs;
    widx = s.aw_addr[AXI_AW-1:2];
    cfg_now = {3'b000, s.interp, s.bw90} ^ {s.nrz, s.nco_en, s.isinc_en, 5'b00000};
    cfg_now = {s.isinc_en, s.nco_en, s.nrz, s.bw90, s.interp};
    take = s.in_ready && in_valid;
    acc = '0;
    sn = sine(s.phase[47:42]);
    cs = sine(s.phase[47:42] + 6'd16);
    next_s = s;
    next_s.flush = 1'b0;
    // register bus: address and data in either order
    if (s.awready && s_axi_awvalid)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid)
    begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (widx == IDX_INTERP)
      begin
        if (s.w_strb[0])
        begin
          next_s.interp = s.w_data[3:0]; // RL16
        end
      end
      else if (widx == IDX_DP_CFG)
      begin
        if (s.w_strb[0])
        begin
          next_s.nrz = s.w_data[CFG_NRZ_BIT]; // RL17
          next_s.bw90 = s.w_data[CFG_BW_BIT]; // RL10
          next_s.nco_en = s.w_data[CFG_NCO_BIT];
        end
      end
      else if (widx == IDX_ISINC)
      begin
        if (s.w_strb[0])
        begin
          next_s.isinc_en = s.w_data[0];
        end
      end
      else if (widx >= IDX_FTW0 && widx <= IDX_FTW5)
      begin
        if (s.w_strb[0])
        begin
          next_s.ftw[8 * 32'(widx - IDX_FTW0) +: 8] = s.w_data[7:0];
        end
      end
      else if (widx == IDX_STATUS)
      begin
        if (s.w_strb[2] && s.w_data[STAT_UFLOW_BIT])
        begin
          next_s.uflow = 1'b0;
        end
      end
      else
      begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    next_s.awready = !next_s.aw_held;
    next_s.wready = !next_s.w_held;
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      case (s_axi_araddr[AXI_AW-1:2])
        IDX_INTERP: next_s.rdata[3:0] = s.interp;
        IDX_DP_CFG:
        begin
          next_s.rdata[CFG_NRZ_BIT] = s.nrz;
          next_s.rdata[CFG_BW_BIT] = s.bw90;
          next_s.rdata[CFG_NCO_BIT] = s.nco_en;
        end
        IDX_ISINC: next_s.rdata[0] = s.isinc_en;
        IDX_STATUS:
        begin
          next_s.rdata[10:0] = latency;
          next_s.rdata[STAT_VALID_BIT] = s.dac_valid;
          next_s.rdata[STAT_UFLOW_BIT] = s.uflow;
        end
        default:
        begin
          if (s_axi_araddr[AXI_AW-1:2] >= IDX_FTW0 && s_axi_araddr[AXI_AW-1:2] <= IDX_FTW5)
          begin
            next_s.rdata[7:0] = s.ftw[8 * 32'(s_axi_araddr[AXI_AW-1:2] - IDX_FTW0) +: 8];
          end
          else
          begin
            next_s.rresp = RESP_SLVERR;
          end
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;
    // mode change restarts the pipeline at the new nominal latency
    if (cfg_now != s.cfg_q)
    begin
      next_s.cfg_q = cfg_now; // RL18
      next_s.flush = 1'b1;
    end
    // input stage: one sample per factor clocks, held between them
    if (s.flush)
    begin
      next_s.cnt = '0; // RL18
      next_s.held = '0;
      next_s.x1 = '0;
      next_s.x2 = '0;
      next_s.sinc = '0;
      next_s.r = '0;
      next_s.r_prev = '0;
    end
    else
    begin
      next_s.cnt = (s.cnt == 5'd0) ? factor_m1(s.interp) : s.cnt - 5'd1; // RL1 RL9
      if (take)
      begin
        next_s.held = in_sample; // RL7 RL2
      end
      else if (s.in_ready)
      begin
        next_s.uflow = 1'b1;
      end
      next_s.x1 = s.held;
      next_s.x2 = s.x1;
      // inverse sinc: three taps, unity DC gain
      if (s.isinc_en)
      begin
        acc = 34'(s.x1.i) * 34'sd18 - 34'(s.held.i) - 34'(s.x2.i);
        next_s.sinc.i = sat16(acc >>> 4); // RL1
        acc = 34'(s.x1.q) * 34'sd18 - 34'(s.held.q) - 34'(s.x2.q);
        next_s.sinc.q = sat16(acc >>> 4);
      end
      else
      begin
        next_s.sinc = s.held;
      end
      // quadrature modulator; with the NCO off the I stream passes on unmodulated
      if (s.nco_en)
      begin
        acc = 34'(s.sinc.i) * 34'(cs) - 34'(s.sinc.q) * 34'(sn); // RL1
        next_s.r = sat16(acc >>> 15);
      end
      else
      begin
        next_s.r = s.sinc.i; // RL3
      end
      next_s.r_prev = s.r;
    end
    next_s.in_ready = (next_s.cnt == 5'd0) && !next_s.flush;
    next_s.phase = s.phase + s.ftw;
    if (take || !s.in_ready)
    begin
      next_s.uflow = next_s.uflow;
    end
    next_s.dac_valid = dly_valid && !s.flush; // RL6
    next_s.dac = next_s.dac_valid ? dly_out : '0; // RL7
  end

  // NRZ stage: second half-slot carries the midpoint sample
  always_comb
  begin
    dly_in.early = s.r_prev;
    dly_in.late = s.nrz ? avg16(s.r_prev, s.r) : s.r_prev; // RL12 RL15 RL17 RL13 RL14 RL11
  end

  assign latency = lat_of(s.interp, s.bw90, s.nrz, s.isinc_en, s.nco_en); // RL4 RL5

  did_delay_line #(
    .DEPTH(DLY_DEPTH)
  ) u_delay (
    .clk(clk),
    .resetn(resetn),
    .clear(s.flush),
    .delay(latency - FIXED_STAGES),
    .din(dly_in),
    .dout(dly_out),
    .dout_valid(dly_valid)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.interp <= RST_INTERP;
      s.ftw <= RST_FTW;
      s.flush <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign in_ready = s.in_ready;
  assign dac_data = s.dac;
  assign dac_valid = s.dac_valid;
endmodule

// File: verification/did_source_model.sv
// Purpose: sample source model for the datapath stream input
// Assumes: offers a sample whenever in_ready is high, unless stalled
// Notes: ramp of step 4 crossing zero; stalled data lines toggle
module did_source_model
  import did_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic stall,
  input wire logic cplx,
  input wire logic in_ready,
  output did_sample_t in_sample,
  output logic in_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] v;
  logic signed [15:0] nv;
  assign nv = (in_valid && in_ready) ? v + 16'sh4 : v;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      v <= -16'sh40;
      in_valid <= 1'b0;
      in_sample <= '0;
    end
    else
    begin
      v <= nv;
      in_valid <= !stall;
      if (stall)
        in_sample <= ~in_sample;
      else
        in_sample <= {nv, cplx ? -nv : 16'sh0};
    end
endmodule

// File: verification/did_datapath_assertions.sv
// Purpose: port-level checks of the interpolation datapath
// Assumes: one clock domain, resetn active low
// Notes: bound to every datapath instance
module did_datapath_assertions
  import did_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input did_pair_t dac_data,
  input wire logic dac_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while data pending");
  aw_drop_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address still open");
  resp_code_a: assert property (
    s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
    else $error("bad write response code");
  b_after_w_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_wready))
    else $error("response before data taken");
  dac_zero_a: assert property (!dac_valid |-> dac_data == '0)
    else $error("output not zero while filling");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(dac_valid));
endmodule
bind did_datapath did_datapath_assertions u_did_datapath_assertions (
  .clk(clk),
  .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .dac_data(dac_data),
  .dac_valid(dac_valid)
);

// File: verification/did_datapath_tb.sv
// Purpose: self-checking bench for the interpolation datapath
// Assumes: 25 MHz clock, source model on the stream input
// Notes: latency table covers every factor code and code 9
module did_datapath_tb
  import did_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, stall = 1'b0, cplx = 1'b0;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, in_ready, in_valid, dac_valid;
  logic [1:0] bresp, rresp, r;
  did_sample_t in_sample;
  did_pair_t dac_data;
  logic signed [15:0] hist [2048];
  logic [10:0] cyc = '0;
  int errors = 0, compares = 0, n;
  int mi[18] = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 2, 2, 3, 4, 5, 6, 7, 8, 9};
  int mc[18] = '{64, 0, 0, 0, 16, 1, 0, 1, 65, 0, 16, 0, 0, 0, 0, 0, 0, 0};
  int ms[18] = '{0, 0, 1, 0, 0, 0, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  int ml[18] = '{48, 113, 137, 155, 176, 202, 185, 239, 279, 168, 202, 308, 332, 602, 674,
    1188, 1272, 113};
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    if (in_valid && in_ready)
      hist[cyc] <= in_sample.i;
    cyc <= cyc + 11'h1;
  end
  did_datapath u_did_datapath (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .in_sample(in_sample), .in_valid(in_valid), .in_ready(in_ready),
    .dac_data(dac_data), .dac_valid(dac_valid));
  did_source_model u_did_source_model (.clk(clk), .resetn(resetn), .stall(stall),
    .cplx(cplx), .in_ready(in_ready), .in_sample(in_sample), .in_valid(in_valid));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] ix, input logic [31:0] v, input logic [3:0] s);
    @(posedge clk);
    awaddr <= {ix, 2'h0};
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] ix);
    @(posedge clk);
    araddr <= {ix, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic set_mode(input int k);
    cplx <= k != 1;
    wr(IDX_INTERP, mi[k], 4'h1);
    wr(IDX_DP_CFG, mc[k], 4'h1);
    wr(IDX_ISINC, ms[k], 4'h1);
    repeat (4) @(posedge clk);
    while (!dac_valid) @(posedge clk);
  endtask
  task automatic t_reset();
    rd(IDX_INTERP);
    chk("interp reset", 32'h0, d);
    rd(IDX_DP_CFG);
    chk("config reset", 32'h0, d);
    rd(IDX_STATUS);
    chk("reset latency", LAT_BYPASS, d[10:0]);
    $display("test reset done");
  endtask
  task automatic t_bad();
    wr(10'h100, 32'h0000_00FF, 4'hF);
    chk("bad write resp", RESP_SLVERR, r);
    rd(10'h100);
    chk("bad read resp", RESP_SLVERR, r);
    chk("bad read data", 32'h0, d);
    wr(IDX_FTW5, 32'h0000_00A5, 4'h1);
    chk("ftw write resp", RESP_OKAY, r);
    rd(IDX_FTW5);
    chk("ftw byte", 32'h0000_00A5, d);
    $display("test unmapped done");
  endtask
  task automatic t_bypass();
    set_mode(1);
    // skip the zero samples still leaving the flushed pipeline
    repeat (8) @(posedge clk);
    repeat (8)
    begin
      @(negedge clk);
      chk("bypass sample", hist[cyc - 11'd114], dac_data.early);
      chk("bypass slots", dac_data.early, dac_data.late);
    end
    $display("test bypass done");
  endtask
  task automatic t_flush();
    wr(IDX_DP_CFG, 32'h0000_0010, 4'h1);
    repeat (2) @(negedge clk);
    chk("flush valid", 32'h0, dac_valid);
    n = 0;
    while (!dac_valid)
    begin
      @(negedge clk);
      n++;
    end
    chk("refill span", 32'h1, n >= 105 && n <= 118);
    $display("test flush done");
  endtask
  task automatic t_modes();
    for (int k = 0; k < 18; k++)
    begin
      set_mode(k);
      rd(IDX_STATUS);
      chk("mode latency", ml[k], d[10:0]);
      chk("mode valid", 32'h1, d[16]);
    end
    $display("test modes done");
  endtask
  task automatic t_slots(input int k, input logic want);
    logic seen;
    set_mode(k);
    seen = 1'b0;
    repeat (16)
    begin
      @(negedge clk);
      if (dac_data.late !== dac_data.early)
        seen = 1'b1;
    end
    chk("late slot differs", want, seen);
    $display("test slots done");
  endtask
  task automatic t_uflow();
    set_mode(3);
    n = 0;
    repeat (8)
    begin
      @(negedge clk);
      n += in_ready;
    end
    chk("ready rate", 32'd4, n);
    stall <= 1'b1;
    repeat (6) @(posedge clk);
    stall <= 1'b0;
    rd(IDX_STATUS);
    chk("underflow set", 32'h1, d[17]);
    wr(IDX_STATUS, 32'h0002_0000, 4'h4);
    rd(IDX_STATUS);
    chk("underflow clear", 32'h0, d[17]);
    $display("test underflow done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_bad();
    t_bypass();
    t_flush();
    t_modes();
    t_slots(5, 1'b1);
    t_slots(3, 1'b0);
    t_uflow();
    results();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    results();
  end
endmodule
